//--- core/ioexp_consts.svh
// constants of the serial port expander and its bus controller
`ifndef IOEXP_CONSTS_SVH
`define IOEXP_CONSTS_SVH
`define ADDR_FIXED       4'h7
`define SEL_IN_LEVEL     2'h0
`define SEL_OUT_LATCH    2'h1
`define SEL_INVERT       2'h2
`define SEL_DIRECTION    2'h3
`define OUT_LATCH_RST    8'hff
`define INVERT_RST       8'h00
`define DIRECTION_RST    8'hff
`define BYTE_BITS        4'h8
`define CLK_PERIOD_NS    50
`define LINK_PERIOD_NS   10000
`define LINK_QUARTER_CYC ((`LINK_PERIOD_NS / `CLK_PERIOD_NS) / 4)
`define CMD_OFS          2'h0
`define STATUS_OFS       2'h1
`define CMD_BYTE_LSB     0
`define CMD_ACKBIT_POS   8
`define CMD_OP_LSB       9
`define STAT_BUSY_POS    0
`define STAT_ACKN_POS    1
`define STAT_RX_LSB      8
`endif

//--- core/ioexp_pkg.sv
// types shared by the expander and its bus controller
package ioexp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6
  } dev_state_type;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_CMD  = 2'h1,
    PH_DATA = 2'h3
  } phase_type;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h3,
    OP_READ  = 2'h2
  } host_op_type;

  typedef struct packed {
    dev_state_type state;
    phase_type     phase;
    logic [3:0]    bitcnt;
    logic [7:0]    shreg;
    logic          rw;
    logic [7:0]    pointer;
    logic [7:0]    out_latch;
    logic [7:0]    invert;
    logic [7:0]    direction;
    logic [7:0]    in_snap;
    logic [1:0]    snap_cnt;
    logic          irq;
    logic          sda_oe;
    logic          scl_q;
    logic          sda_q;
  } dev_state_rec_type;

  typedef struct packed {
    logic        busy;
    host_op_type op;
    logic [3:0]  bitidx;
    logic [1:0]  quarter;
    logic [15:0] tick;
    logic        scl_oe;
    logic        sda_oe;
    logic [8:0]  shreg;
    logic [7:0]  rx;
    logic        ack_n;
    logic        rd_done;
    logic [31:0] readdata;
  } host_state_rec_type;
endpackage : ioexp_pkg

//--- core/i2c_link_if.sv
// two-wire link between bus controller and expander
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open drain with pull-up: any enabled low driver wins
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport host (
    output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
    input  scl, sda
  );
  modport dev (
    output dev_sda_out, dev_sda_oe,
    input  scl, sda
  );
endinterface : i2c_link_if
`default_nettype wire

//--- core/sync2.sv
// two flip-flop synchroniser for pins from outside
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

//--- core/i2c_expander_dev.sv
// serial slave and register set of the 8-bit port expander
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.svh"
module i2c_expander_dev (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // link
  i2c_link_if.dev         link,
  // address straps
  input  wire logic       strap_sel_hi_in,
  input  wire logic       strap_sel_mid_in,
  input  wire logic       strap_sel_lo_in,
  // port pins
  input  wire logic [7:0] port_pins_in,
  output logic      [7:0] port_pins_out,
  output logic      [7:0] port_pins_oe_out,
  // open-drain interrupt
  output logic            irq_n_out,
  output logic            irq_n_oe_out
);
  import ioexp_pkg::*;

  ioexp_pkg::dev_state_rec_type r;
  ioexp_pkg::dev_state_rec_type next_r;

  logic [12:0] sync_q;
  logic        s_scl;
  logic        s_sda;
  logic [7:0]  s_pins;
  logic [2:0]  s_strap;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        addr_match;
  logic [7:0]  sensed;
  logic [7:0]  rd_val;

  sync2 #(
    .WIDTH(13)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .d_in       ({link.scl, link.sda, port_pins_in,
                  strap_sel_hi_in, strap_sel_mid_in, strap_sel_lo_in}),
    .q_out      (sync_q)
  );

  assign s_scl   = sync_q[12];
  assign s_sda   = sync_q[11];
  assign s_pins  = sync_q[10:3];
  assign s_strap = sync_q[2:0];

  assign scl_rise   = s_scl & ~r.scl_q;
  assign scl_fall   = ~s_scl & r.scl_q;
  // start and stop are data edges while clock stays high
  assign start_seen = s_scl & r.scl_q & r.sda_q & ~s_sda;
  assign stop_seen  = s_scl & r.scl_q & ~r.sda_q & s_sda;
  assign addr_match = (r.shreg[7:1] == {`ADDR_FIXED, s_strap});
  assign sensed     = s_pins ^ r.invert;

  // only the two select bits count
  always_comb begin
    case (r.pointer[1:0])
      `SEL_IN_LEVEL:  rd_val = sensed;
      `SEL_OUT_LATCH: rd_val = r.out_latch;
      `SEL_INVERT:    rd_val = r.invert;
      `SEL_DIRECTION: rd_val = r.direction;
      default:        rd_val = sensed;
    endcase
  end

  always_comb begin
    next_r       = r;
    next_r.scl_q = s_scl;
    next_r.sda_q = s_sda;

    // synchroniser shows zeros for two edges, so wait before the snapshot
    if (r.snap_cnt != 2'h3) begin
      next_r.in_snap  = s_pins;
      next_r.snap_cnt = r.snap_cnt + 2'h1;
    end
    // output pins are masked off by the direction bits
    next_r.irq = (r.snap_cnt == 2'h3) &
                 (|((s_pins ^ r.in_snap) & r.direction));

    if (start_seen) begin
      // repeated start keeps the pointer
      next_r.state  = ST_RX;
      next_r.phase  = PH_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_r.state  = ST_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      case (r.state)
        ST_RX: begin
          if (scl_rise) begin
            next_r.shreg  = {r.shreg[6:0], s_sda};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
          if (scl_fall && r.bitcnt == `BYTE_BITS) begin
            next_r.bitcnt = 4'h0;
            case (r.phase)
              PH_ADDR: begin
                if (addr_match) begin
                  next_r.rw     = r.shreg[0];
                  next_r.sda_oe = 1'b1;
                  next_r.state  = ST_ACK;
                  next_r.phase  = r.shreg[0] ? PH_DATA : PH_CMD;
                end else begin
                  // other devices' traffic is ignored until next start
                  next_r.state = ST_IDLE;
                end
              end
              PH_CMD: begin
                next_r.pointer = r.shreg;
                next_r.sda_oe  = 1'b1;
                next_r.state   = ST_ACK;
                next_r.phase   = PH_DATA;
              end
              default: begin
                // same target for every byte, no increment
                case (r.pointer[1:0])
                  `SEL_OUT_LATCH: next_r.out_latch = r.shreg;
                  `SEL_INVERT:    next_r.invert    = r.shreg;
                  `SEL_DIRECTION: next_r.direction = r.shreg;
                  default:        next_r.out_latch = r.out_latch;
                endcase
                next_r.sda_oe = 1'b1;
                next_r.state  = ST_ACK;
              end
            endcase
          end
        end
        ST_ACK: begin
          // low held from one falling edge to the next
          if (scl_rise && r.rw) begin
            next_r.shreg = rd_val;
            if (r.pointer[1:0] == `SEL_IN_LEVEL) begin
              next_r.in_snap = s_pins;
            end
          end
          if (scl_fall) begin
            if (r.rw) begin
              next_r.state  = ST_TX;
              next_r.bitcnt = 4'h0;
              next_r.sda_oe = ~r.shreg[7];
            end else begin
              next_r.state  = ST_RX;
              next_r.sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'h7) begin
              next_r.state  = ST_MACK;
              next_r.sda_oe = 1'b0;
            end else begin
              next_r.shreg  = {r.shreg[6:0], 1'b0};
              next_r.bitcnt = r.bitcnt + 4'h1;
              next_r.sda_oe = ~r.shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (s_sda) begin
              // released line: last byte, wait for stop
              next_r.state = ST_IDLE;
            end else begin
              next_r.shreg = rd_val;
              if (r.pointer[1:0] == `SEL_IN_LEVEL) begin
                next_r.in_snap = s_pins;
              end
            end
          end
          if (scl_fall && r.state == ST_MACK) begin
            next_r.state  = ST_TX;
            next_r.bitcnt = 4'h0;
            next_r.sda_oe = ~r.shreg[7];
          end
        end
        default: begin
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r           <= '0;
      r.state     <= ST_IDLE;
      r.phase     <= PH_ADDR;
      r.out_latch <= `OUT_LATCH_RST;
      r.invert    <= `INVERT_RST;
      r.direction <= `DIRECTION_RST;
    end else begin
      r <= next_r;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe  = r.sda_oe;
  assign port_pins_out    = r.out_latch;
  assign port_pins_oe_out = ~r.direction;
  assign irq_n_out        = 1'b0;
  assign irq_n_oe_out     = r.irq;
endmodule : i2c_expander_dev
`default_nettype wire

//--- core/i2c_host_ctrl.sv
// bus controller: Avalon-MM command slave driving the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.svh"
module i2c_host_ctrl #(
  parameter int QUARTER_CYC = `LINK_QUARTER_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // link
  i2c_link_if.host         link
);
  import ioexp_pkg::*;

  ioexp_pkg::host_state_rec_type r;
  ioexp_pkg::host_state_rec_type next_r;

  logic       s_sda;
  logic       take_wr;

  // no clock stretching, so only the data line is sampled
  sync2 #(
    .WIDTH(1)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .d_in       (link.sda),
    .q_out      (s_sda)
  );

  // a command write stalls until the previous one has finished
  assign avs_waitrequest_out = (avs_write_in & r.busy) |
                               (avs_read_in & ~r.rd_done);
  assign take_wr = avs_write_in & ~r.busy;

  always_comb begin
    next_r = r;
    next_r.rd_done = avs_read_in & ~r.rd_done;
    if (avs_read_in && !r.rd_done) begin
      next_r.readdata = 32'h0;
      if (avs_address_in[3:2] == `STATUS_OFS) begin
        next_r.readdata[`STAT_BUSY_POS] = r.busy;
        next_r.readdata[`STAT_ACKN_POS] = r.ack_n;
        next_r.readdata[`STAT_RX_LSB +: 8] = r.rx;
      end
    end
    if (take_wr && avs_address_in[3:2] == `CMD_OFS) begin
      next_r.busy    = 1'b1;
      next_r.op      = host_op_type'(avs_writedata_in[`CMD_OP_LSB +: 2]);
      next_r.bitidx  = 4'h0;
      next_r.quarter = 2'h0;
      next_r.tick    = 16'(QUARTER_CYC - 1);
      // write: data then a released ack slot; read: released then ack bit
      if (host_op_type'(avs_writedata_in[`CMD_OP_LSB +: 2]) == OP_WRITE) begin
        next_r.shreg = {avs_writedata_in[`CMD_BYTE_LSB +: 8], 1'b1};
      end else begin
        next_r.shreg = {8'hff, avs_writedata_in[`CMD_ACKBIT_POS]};
      end
    end else if (r.busy) begin
      if (r.tick != 16'h0) begin
        next_r.tick = r.tick - 16'h1;
      end else begin
        next_r.tick    = 16'(QUARTER_CYC - 1);
        next_r.quarter = r.quarter + 2'h1;
        case (r.op)
          OP_START: begin
            // also serves as repeated start from a low clock
            case (r.quarter)
              2'h0:    next_r.sda_oe = 1'b0;
              2'h1:    next_r.scl_oe = 1'b0;
              2'h2:    next_r.sda_oe = 1'b1;
              default: begin
                next_r.scl_oe = 1'b1;
                next_r.busy   = 1'b0;
              end
            endcase
          end
          OP_STOP: begin
            case (r.quarter)
              2'h0: begin
                next_r.scl_oe = 1'b1;
                next_r.sda_oe = 1'b1;
              end
              2'h1:    next_r.scl_oe = 1'b0;
              2'h2:    next_r.sda_oe = 1'b0;
              default: next_r.busy   = 1'b0;
            endcase
          end
          default: begin
            // nine bit slots: eight data plus acknowledge
            case (r.quarter)
              2'h0:    next_r.sda_oe = ~r.shreg[8];
              2'h1:    next_r.scl_oe = 1'b0;
              2'h2:    next_r.shreg  = {r.shreg[7:0], s_sda};
              default: begin
                next_r.scl_oe = 1'b1;
                if (r.bitidx == `BYTE_BITS) begin
                  next_r.busy   = 1'b0;
                  next_r.sda_oe = 1'b0;
                  next_r.rx     = r.shreg[8:1];
                  next_r.ack_n  = r.shreg[0];
                end else begin
                  next_r.bitidx = r.bitidx + 4'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r    <= '0;
      r.op <= OP_START;
    end else begin
      r <= next_r;
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe  = r.scl_oe;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe  = r.sda_oe;
  assign avs_readdata_out  = r.readdata;
endmodule : i2c_host_ctrl
`default_nettype wire

//--- tb/ioexp_link_sva.sv
// link checker for the expander two-wire bus
`timescale 1ns/1ps
`default_nettype none
module ioexp_link_sva (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // link
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] cnt;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // clock rises since the last start, saturating
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 4'h0;
    end else if ($fell(sda) && scl) begin
      cnt <= 4'h0;
    end else if ($rose(scl) && cnt != 4'hf) begin
      cnt <= cnt + 4'h1;
    end
  end

  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_sender_release: assert property (
    $rose(host_sda_oe) |-> !dev_sda_oe)
    else $error("device still drives data when host takes it");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  a_host_frames: assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
    else $error("data moved in clock high not by host");
  a_ack_hold: assert property (
    $rose(scl) && dev_sda_oe |-> dev_sda_oe[*8])
    else $error("acknowledge not held through clock high");
  a_stop_release: assert property (
    $rose(sda) && scl |-> (!dev_sda_oe)[*8])
    else $error("device drives after stop");
  a_start_clocks: assert property ($fell(sda) && scl |-> ##[1:40] !scl)
    else $error("no clock after start");
  a_addr_quiet: assert property (
    $rose(scl) && cnt < 4'h8 |-> !dev_sda_oe)
    else $error("device drives during address byte");

  // bus ticks: start always precedes ack; low-clock glitches would hide here
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_ack: cover property ($rose(scl) && dev_sda_oe);
endmodule : ioexp_link_sva
`default_nettype wire

//--- tb/test_i2c_io_expander_regs.sv
// self-checking bench for the port expander and its bus controller
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.svh"
module test_i2c_io_expander_regs;
  import ioexp_pkg::*;
  logic        clk_sys_in;
  logic        rst_n_in;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [2:0]  strap;
  logic [7:0]  pins_in;
  logic [7:0]  pins_out;
  logic [7:0]  pins_oe;
  logic        irq_n;
  logic        irq_oe;
  int          fail_count;
  int          n_checks;

  i2c_link_if link ();

  // short quarter keeps the run brief; 4 is the safe floor
  i2c_host_ctrl #(.QUARTER_CYC(8)) i2c_host_ctrl_i (
    .clk_sys_in          (clk_sys_in),
    .rst_n_in            (rst_n_in),
    .avs_address_in      (av_addr),
    .avs_read_in         (av_rd),
    .avs_write_in        (av_wr),
    .avs_writedata_in    (av_wdata),
    .avs_readdata_out    (av_rdata),
    .avs_waitrequest_out (av_wait),
    .link                (link)
  );

  i2c_expander_dev i2c_expander_dev_i (
    .clk_sys_in       (clk_sys_in),
    .rst_n_in         (rst_n_in),
    .link             (link),
    .strap_sel_hi_in  (strap[2]),
    .strap_sel_mid_in (strap[1]),
    .strap_sel_lo_in  (strap[0]),
    .port_pins_in     (pins_in),
    .port_pins_out    (pins_out),
    .port_pins_oe_out (pins_oe),
    .irq_n_out        (irq_n),
    .irq_n_oe_out     (irq_oe)
  );

  ioexp_link_sva ioexp_link_sva_i (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .host_scl_oe (link.host_scl_oe),
    .host_sda_oe (link.host_sda_oe),
    .dev_sda_oe  (link.dev_sda_oe),
    .scl         (link.scl),
    .sda         (link.sda)
  );

  task automatic results;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one avalon cycle; held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_in);
    av_addr  <= a;
    av_rd    <= rd;
    av_wr    <= ~rd;
    av_wdata <= d;
    do @(posedge clk_sys_in); while (av_wait !== 1'b0);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : bus

  // one link operation, then poll until the controller is idle
  task automatic op(input logic [1:0] o, input logic [7:0] b,
                    input logic nk, output logic [31:0] st);
    bus(1'b0, 4'h0, {21'h0, o, nk, b}, st);
    do bus(1'b1, 4'h4, 32'h0, st); while (st[0] !== 1'b0);
  endtask : op

  task automatic wr_reg(input logic [7:0] c, input logic [15:0] d,
                        input int n);
    logic [31:0] st;
    op(OP_START, 8'h0, 1'b0, st);
    op(OP_WRITE, {`ADDR_FIXED, strap, 1'b0}, 1'b0, st);
    chk(st[1], 1'b0);
    op(OP_WRITE, c, 1'b0, st);
    chk(st[1], 1'b0);
    for (int i = 0; i < n; i++) begin
      op(OP_WRITE, d[8*i +: 8], 1'b0, st);
      chk(st[1], 1'b0);
    end
    op(OP_STOP, 8'h0, 1'b0, st);
  endtask : wr_reg

  // n reads of one register, the last one not acknowledged
  task automatic rd_reg(input logic sc, input logic [7:0] c,
                        input logic [7:0] e, input int n);
    logic [31:0] st;
    if (sc) begin
      op(OP_START, 8'h0, 1'b0, st);
      op(OP_WRITE, {`ADDR_FIXED, strap, 1'b0}, 1'b0, st);
      op(OP_WRITE, c, 1'b0, st);
    end
    op(OP_START, 8'h0, 1'b0, st);
    op(OP_WRITE, {`ADDR_FIXED, strap, 1'b1}, 1'b0, st);
    chk(st[1], 1'b0);
    for (int i = 0; i < n; i++) begin
      op(OP_READ, 8'h0, i == n - 1, st);
      chk(st[15:8], e);
    end
    op(OP_STOP, 8'h0, 1'b0, st);
  endtask : rd_reg

  task automatic t_reset;
    chk(pins_oe, 8'h00);
    chk(pins_out, 8'hff);
    rd_reg(1'b1, 8'h01, 8'hff, 1);
    chk(irq_oe, 1'b0);
    rd_reg(1'b1, 8'h02, 8'h00, 1);
    rd_reg(1'b1, 8'h03, 8'hff, 1);
  endtask : t_reset

  task automatic t_regs;
    wr_reg(8'hfb, 16'h5a0f, 2);
    rd_reg(1'b1, 8'h03, 8'h5a, 2);
    chk(pins_oe, 8'ha5);
    wr_reg(8'h01, 16'h00c3, 1);
    chk(pins_out, 8'hc3);
    rd_reg(1'b1, 8'h01, 8'hc3, 2);
  endtask : t_regs

  task automatic t_input;
    pins_in <= 8'h96;
    wr_reg(8'h02, 16'h000f, 1);
    rd_reg(1'b1, 8'h00, 8'h99, 1);
    wr_reg(8'h00, 16'h0055, 1);
    rd_reg(1'b0, 8'h00, 8'h99, 2);
  endtask : t_input

  // inputs are bits 1,3,4,6; pin sync needs a few cycles
  task automatic t_irq;
    pins_in <= 8'h97;
    repeat (8) @(posedge clk_sys_in);
    chk(irq_oe, 1'b0);
    pins_in <= 8'h94;
    repeat (8) @(posedge clk_sys_in);
    chk(irq_oe, 1'b1);
    pins_in <= 8'h96;
    repeat (8) @(posedge clk_sys_in);
    chk(irq_oe, 1'b0);
    pins_in <= 8'h86;
    repeat (8) @(posedge clk_sys_in);
    chk(irq_oe, 1'b1);
    rd_reg(1'b0, 8'h00, 8'h89, 1);
    chk(irq_oe, 1'b0);
    chk(irq_n, 1'b0);
  endtask : t_irq

  task automatic t_addr;
    logic [31:0] st;
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      repeat (4) @(posedge clk_sys_in);
      op(OP_START, 8'h0, 1'b0, st);
      op(OP_WRITE, {`ADDR_FIXED, 3'(s) ^ 3'h5, 1'b0}, 1'b0, st);
      chk(st[1], 1'b1);
      op(OP_STOP, 8'h0, 1'b0, st);
      rd_reg(1'b1, 8'h03, 8'h5a, 1);
    end
  endtask : t_addr

  // unmapped place: write ignored, read gives zero
  task automatic t_map;
    logic [31:0] q;
    bus(1'b0, 4'h8, 32'hffff_ffff, q);
    bus(1'b1, 4'h8, 32'h0, q);
    chk(q, 32'h0);
  endtask : t_map

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // about three times the expected run
  initial begin
    #4_000_000;
    fail_count++;
    results();
  end

  initial begin
    fail_count = 0;
    n_checks   = 0;
    rst_n_in   = 1'b0;
    av_addr    = 4'h0;
    av_rd      = 1'b0;
    av_wr      = 1'b0;
    av_wdata   = 32'h0;
    strap      = 3'h0;
    pins_in    = 8'h3c;
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_reset();
    t_regs();
    t_input();
    t_irq();
    t_addr();
    t_map();
    results();
  end
endmodule : test_i2c_io_expander_regs
`default_nettype wire
